/* logic/tlh_host_port.sv */
`timescale 1ns/10ps
`include "tlh_map.svh"
// What this block does
// - Upper buffer address floats except own access address and transfer time
// - Page bits follow last enable command page
// - Eight lines carry address byte and data
// - Qualifiers sampled at strobe falling edge
// - Direction held in strobe-gated latch
// - Arbitration starts at strobe falling edge
// - Request output is latched io or memory
// - Wait asserted at start, released when ready
// - Writes wait for late write valid
// - Interrupt follows unmasked status bits
// - Latch and data enables gate write data
// - Upper address enable on buffer memory accesses
// - Latch pulse during buffer address time
// - Write pulse, data valid at trailing edge
// - Output enable during buffer read data
// - Single load pulse for node ID
// - ID shifted msb first, high is one
// - Inhibit forces both pulse outputs high
// - Echo input low retransmits short messages
// - All timing from the one clock
// - Reset clears state, sets power-on status
module tlh_host_port (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic addr_strobe_i,
    input wire tlh_pkg::tlh_req_t req_i,
    input wire logic late_write_valid_i,
    input wire logic [7:0] proc_addr_data_bus_i,
    input wire logic [7:0] buffer_addr_data_bus_i,
    output logic [7:0] buffer_addr_data_bus_o,
    output logic buffer_addr_data_bus_oe_o,
    output logic [2:0] buffer_page_addr_hi_o,
    output logic buffer_page_addr_hi_oe_o,
    output logic request_ack_o,
    output logic wait_o,
    output logic irq_out_o,
    output logic iface_latch_enable_o,
    output logic addr_data_in_enable_o,
    output logic upper_addr_in_enable_o,
    output tlh_pkg::tlh_ram_t ram_o,
    output logic node_id_load_o,
    input wire logic node_id_serial_in_i,
    output logic [7:0] node_id_o,
    input wire logic [1:0] timeout_select_i,
    input wire logic tx_inhibit_n_i,
    input wire logic tx_pulse_a_i,
    input wire logic tx_pulse_b_i,
    output logic line_pulse_a_o,
    output logic line_pulse_b_o,
    input wire logic echo_n_i,
    input wire logic [8:0] rx_len_i,
    input wire logic rx_done_i,
    output logic echo_req_o,
    input wire logic [7:0] event_i,
    output logic [7:0] status_o,
    output logic [1:0] timeout_sel_o
);
    import tlh_pkg::*;

    // ==========================================================
    // Strobe sampling
    // ==========================================================
    logic as_d_reg, as_d_next; // Previous strobe level
    tlh_req_t qual_reg, qual_next; // Latched qualifiers
    logic as_fall;
    assign as_fall = as_d_reg && !addr_strobe_i;
    // Strobe high keeps latch open, low holds it
    always_comb begin
        as_d_next = addr_strobe_i;
        qual_next = qual_reg;
        if (addr_strobe_i) begin
            qual_next = req_i;
        end
    end
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            as_d_reg <= 1'b1;
            qual_reg <= '0;
        end else begin
            as_d_reg <= as_d_next;
            qual_reg <= qual_next;
        end
    end

    // ==========================================================
    // Access sequencer
    // ==========================================================
    tlh_state_t st_reg, st_next;
    tlh_req_t cyc_reg, cyc_next; // Qualifiers of the running cycle
    logic [1:0] cnt_reg, cnt_next; // Transfer time counter
    logic [7:0] addr_reg, addr_next; // Low address byte
    logic [1:0] page_reg, page_next; // Page from last enable command
    logic [7:0] mask_reg, mask_next; // Interrupt mask
    logic [7:0] stat_reg, stat_next; // Sticky status
    logic [7:0] rdat_reg, rdat_next; // Read data for processor
    logic [1:0] tsel_reg, tsel_next; // Sampled timeout select
    logic wait_reg, wait_next;
    logic reqa_reg, reqa_next;
    logic irq_reg, irq_next;
    logic ile_reg, ile_next;
    logic addr_data_in_enable_reg, addr_data_in_enable_next;
    logic aie_reg, aie_next;
    logic hiz_reg, hiz_next; // High address drive
    logic oe_reg, oe_next;
    logic we_reg, we_next;
    logic lat_reg, lat_next;
    logic echo_reg, echo_next;
    logic pa_reg, pa_next;
    logic pb_reg, pb_next;
    logic [7:0] clr_bits;
    logic [3:0] cmd;
    assign cmd = proc_addr_data_bus_i[7:4];
    // Sequencer, strobes and command decode
    always_comb begin
        st_next = st_reg;
        cyc_next = cyc_reg;
        cnt_next = cnt_reg;
        addr_next = addr_reg;
        page_next = page_reg;
        mask_next = mask_reg;
        rdat_next = rdat_reg;
        clr_bits = 8'h00;
        wait_next = wait_reg;
        ile_next = 1'b0;
        addr_data_in_enable_next = 1'b0;
        aie_next = 1'b0;
        hiz_next = 1'b0;
        oe_next = 1'b0;
        we_next = 1'b0;
        lat_next = 1'b0;
        reqa_next = qual_next.io_cycle_request
            | qual_next.memory_cycle_request;
        case (st_reg)
            TLH_IDLE: begin
                // Arbitration begins on the strobe edge
                if (as_fall && (req_i.io_cycle_request
                    || req_i.memory_cycle_request)) begin
                    cyc_next = qual_reg;
                    cyc_next.io_cycle_request = req_i.io_cycle_request;
                    cyc_next.memory_cycle_request =
                        req_i.memory_cycle_request;
                    wait_next = 1'b1;
                    addr_next = proc_addr_data_bus_i;
                    st_next = TLH_ADDR;
                end
            end
            TLH_ADDR: begin
                // Address valid time: pulse latch for buffer cycles
                addr_data_in_enable_next = 1'b1;
                if (cyc_reg.memory_cycle_request) begin
                    lat_next = 1'b1;
                    aie_next = 1'b1;
                end
                st_next = cyc_reg.rd_not_wr ? TLH_XFER : TLH_WDAT;
                cnt_next = 2'(`TLH_ACC_CYC);
            end
            TLH_WDAT: begin
                // Writes hold off until data is valid
                aie_next = cyc_reg.memory_cycle_request;
                if (late_write_valid_i) begin
                    st_next = TLH_XFER;
                end
            end
            TLH_XFER: begin
                aie_next = cyc_reg.memory_cycle_request;
                if (!cyc_reg.rd_not_wr) begin
                    ile_next = 1'b1;
                    addr_data_in_enable_next = 1'b1;
                    we_next = cyc_reg.memory_cycle_request
                        && cnt_reg != 2'h1;
                end else if (cyc_reg.memory_cycle_request) begin
                    oe_next = 1'b1;
                    rdat_next = buffer_addr_data_bus_i;
                end else begin
                    rdat_next = stat_reg;
                end
                if (cnt_reg == 2'h1) begin
                    st_next = TLH_DONE;
                end else begin
                    cnt_next = cnt_reg - 2'h1;
                end
            end
            TLH_DONE: begin
                // Commands act on the written data byte
                if (cyc_reg.io_cycle_request && !cyc_reg.rd_not_wr
                    && !proc_addr_data_bus_i[0]) begin
                    case (cmd)
                        `TLH_CMD_EN_TX, `TLH_CMD_EN_RX: begin
                            page_next = proc_addr_data_bus_i[2:1];
                        end
                        `TLH_CMD_CLR: begin
                            clr_bits = proc_addr_data_bus_i;
                        end
                        default: begin
                            page_next = page_reg;
                        end
                    endcase
                end else if (cyc_reg.io_cycle_request
                    && !cyc_reg.rd_not_wr) begin
                    // Bit 0 selects this write, so its mask bit clears
                    mask_next = {proc_addr_data_bus_i[7:1], 1'b0};
                end
                wait_next = 1'b0;
                st_next = TLH_IDLE;
            end
            default: begin
                st_next = TLH_IDLE;
            end
        endcase
        // Own buffer access address and transfer time: drive upper address, else float
        hiz_next = (st_next == TLH_XFER || st_next == TLH_ADDR)
            && cyc_next.memory_cycle_request;
        // Events set sticky bits; set wins over clear
        stat_next = (stat_reg & ~clr_bits) | event_i;
        irq_next = |(stat_next & mask_next);
        // Echo when enabled by a low input and message short
        echo_next = rx_done_i && !echo_n_i
            && rx_len_i < `TLH_ECHO_MAX;
        pa_next = tx_pulse_a_i | ~tx_inhibit_n_i;
        pb_next = tx_pulse_b_i | ~tx_inhibit_n_i;
        tsel_next = timeout_select_i;
    end
    // Registers; power-on status set on reset
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_reg <= TLH_IDLE;
            cyc_reg <= '0;
            cnt_reg <= 2'h0;
            addr_reg <= 8'h00;
            page_reg <= `TLH_PAGE_RST;
            mask_reg <= `TLH_MASK_RST;
            stat_reg <= `TLH_STAT_POR;
            rdat_reg <= 8'h00;
            tsel_reg <= 2'h0;
            wait_reg <= 1'b0;
            reqa_reg <= 1'b0;
            irq_reg <= 1'b1;
            ile_reg <= 1'b0;
            addr_data_in_enable_reg <= 1'b0;
            aie_reg <= 1'b0;
            hiz_reg <= 1'b0;
            oe_reg <= 1'b0;
            we_reg <= 1'b0;
            lat_reg <= 1'b0;
            echo_reg <= 1'b0;
            pa_reg <= 1'b1;
            pb_reg <= 1'b1;
        end else begin
            st_reg <= st_next;
            cyc_reg <= cyc_next;
            cnt_reg <= cnt_next;
            addr_reg <= addr_next;
            page_reg <= page_next;
            mask_reg <= mask_next;
            stat_reg <= stat_next;
            rdat_reg <= rdat_next;
            tsel_reg <= tsel_next;
            wait_reg <= wait_next;
            reqa_reg <= reqa_next;
            irq_reg <= irq_next;
            ile_reg <= ile_next;
            addr_data_in_enable_reg <= addr_data_in_enable_next;
            aie_reg <= aie_next;
            hiz_reg <= hiz_next;
            oe_reg <= oe_next;
            we_reg <= we_next;
            lat_reg <= lat_next;
            echo_reg <= echo_next;
            pa_reg <= pa_next;
            pb_reg <= pb_next;
        end
    end

    // ==========================================================
    // Node ID loader
    // ==========================================================
    logic [7:0] id_w;
    logic id_ld_w;
    tlh_id_shift #(.ID_W(8)) u_id (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .node_id_serial_in_i(node_id_serial_in_i),
        .node_id_load_o(id_ld_w),
        .node_id_o(id_w),
        .id_valid_o()
    );
    logic idl_reg;
    logic [7:0] idv_reg;
    // Retime loader outputs
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            idl_reg <= 1'b0;
            idv_reg <= 8'h00;
        end else begin
            idl_reg <= id_ld_w;
            idv_reg <= id_w;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign buffer_addr_data_bus_o = oe_reg ? 8'h00
        : (lat_reg ? addr_reg : rdat_reg);
    assign buffer_addr_data_bus_oe_o = lat_reg;
    assign buffer_page_addr_hi_o = {page_reg, addr_reg[0]};
    assign buffer_page_addr_hi_oe_o = hiz_reg;
    assign request_ack_o = reqa_reg;
    assign wait_o = wait_reg;
    assign irq_out_o = irq_reg;
    assign iface_latch_enable_o = ile_reg;
    assign addr_data_in_enable_o = addr_data_in_enable_reg;
    assign upper_addr_in_enable_o = aie_reg;
    assign ram_o = '{latch_pulse: lat_reg, write_pulse: we_reg,
        output_en: oe_reg};
    assign node_id_load_o = idl_reg;
    assign node_id_o = idv_reg;
    assign line_pulse_a_o = pa_reg;
    assign line_pulse_b_o = pb_reg;
    assign echo_req_o = echo_reg;
    assign status_o = stat_reg;
    assign timeout_sel_o = tsel_reg;

    // ==========================================================
    // Checks
    // ==========================================================
    inhibit_pulse_a: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        !tx_inhibit_n_i |=> line_pulse_a_o && line_pulse_b_o)
        else $error("pulses not forced high under inhibit");
    wait_start_a: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        st_reg == TLH_IDLE && st_next == TLH_ADDR |=> wait_o)
        else $error("wait not raised at cycle start");
    write_hold_a: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        st_reg == TLH_WDAT && !late_write_valid_i |=> wait_o
        && st_reg == TLH_WDAT)
        else $error("write finished without late write valid");
    page_float_a: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        buffer_page_addr_hi_oe_o |-> cyc_reg.memory_cycle_request)
        else $error("upper address driven outside buffer access");
    latch_addr_a: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        ram_o.latch_pulse |-> $past(st_reg) == TLH_ADDR)
        else $error("latch pulse outside address time");
    read_oe_a: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        ram_o.output_en |-> cyc_reg.rd_not_wr && !ram_o.write_pulse)
        else $error("output enable on a write");
    irq_mask_a: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        ##1 irq_out_o == |(status_o & mask_reg))
        else $error("interrupt disagrees with status and mask");
    reqack_a: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        addr_strobe_i |=> request_ack_o == ($past(req_i.io_cycle_request)
        | $past(req_i.memory_cycle_request)))
        else $error("request ack not latched io or memory");
    wr_ile_a: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        iface_latch_enable_o |-> addr_data_in_enable_o)
        else $error("latch enable without data enable");
    cov_rd_c: cover property (@(posedge mclk_i) ram_o.output_en);
    cov_wr_c: cover property (@(posedge mclk_i) ram_o.write_pulse);
    cov_io_c: cover property (@(posedge mclk_i)
        st_reg == TLH_DONE && cyc_reg.io_cycle_request);
endmodule : tlh_host_port

/* logic/tlh_map.svh */
`ifndef TLH_MAP_SVH
`define TLH_MAP_SVH
// ==========================================================
// Timing counts and field values
// ==========================================================
// Clock period in ns (5 MHz device clock)
`define TLH_CLK_NS 200
// Wait time before a device cycle completes, in ns
`define TLH_ACC_NS 400
// Cycles derived from the above, rounded up
`define TLH_ACC_CYC ((`TLH_ACC_NS + `TLH_CLK_NS - 1) / `TLH_CLK_NS)
// Node ID width in bits
`define TLH_ID_W 8
// Echo limit in bytes
`define TLH_ECHO_MAX 9'h0FE
// Reset values
`define TLH_PAGE_RST 2'h0
`define TLH_MASK_RST 8'h01
`define TLH_STAT_POR 8'h01
// Command codes in the high nibble of the data byte
`define TLH_CMD_EN_TX 4'h3
`define TLH_CMD_EN_RX 4'h4
`define TLH_CMD_CLR 4'h5
`define TLH_CMD_MASK 4'h6
`endif

/* logic/tlh_pkg.sv */
// ==========================================================
// Shared types
// ==========================================================
package tlh_pkg;
    // Processor side request qualifiers
    typedef struct packed {
        logic io_cycle_request;
        logic memory_cycle_request;
        logic rd_not_wr;
    } tlh_req_t;
    // RAM strobes toward the buffer
    typedef struct packed {
        logic latch_pulse;
        logic write_pulse;
        logic output_en;
    } tlh_ram_t;
    // Access sequencer states, one-hot
    typedef enum logic [4:0] {
        TLH_IDLE = 5'b00001,
        TLH_ADDR = 5'b00010,
        TLH_WDAT = 5'b00100,
        TLH_XFER = 5'b01000,
        TLH_DONE = 5'b10000
    } tlh_state_t;
endpackage : tlh_pkg

/* logic/tlh_id_shift.sv */
`timescale 1ns/10ps
`include "tlh_map.svh"
// ==========================================================
// Node ID serial loader
// ==========================================================
module tlh_id_shift #(
    parameter int ID_W = `TLH_ID_W
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic node_id_serial_in_i,
    output logic node_id_load_o,
    output logic [ID_W-1:0] node_id_o,
    output logic id_valid_o
);
    // Bit counter and shift state
    logic [4:0] cnt_reg, cnt_next;
    logic [ID_W-1:0] sh_reg, sh_next;
    logic ld_reg, ld_next;
    logic vld_reg, vld_next;
    // Next state: one load pulse then ID_W shifts, msb first
    always_comb begin
        cnt_next = cnt_reg;
        sh_next = sh_reg;
        ld_next = 1'b0;
        vld_next = vld_reg;
        if (!vld_reg) begin
            if (cnt_reg == 5'h00) begin
                ld_next = 1'b1;
                cnt_next = 5'h01;
            end else if (cnt_reg < 5'h03) begin
                // Pin retime plus external load: msb not out yet
                cnt_next = cnt_reg + 5'h01;
            end else begin
                // High level shifts in a one
                sh_next = {sh_reg[ID_W-2:0], node_id_serial_in_i};
                if (cnt_reg == 5'(ID_W + 2)) begin
                    vld_next = 1'b1;
                end
                cnt_next = cnt_reg + 5'h01;
            end
        end
    end
    // Registers
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_reg <= 5'h00;
            sh_reg <= '0;
            ld_reg <= 1'b0;
            vld_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            sh_reg <= sh_next;
            ld_reg <= ld_next;
            vld_reg <= vld_next;
        end
    end
    assign node_id_load_o = ld_reg;
    assign node_id_o = sh_reg;
    assign id_valid_o = vld_reg;

    load_once_a: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        node_id_load_o |=> !node_id_load_o)
        else $error("id load longer than one cycle");
    shift_msb_a: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        !id_valid_o && !node_id_load_o && cnt_reg >= 5'h03
        |=> node_id_o[0] == $past(node_id_serial_in_i))
        else $error("serial id bit not shifted in");
endmodule : tlh_id_shift

/* tb/tlh_ram_model.sv */
`timescale 1ns/10ps
// ==========================================================
// Buffer RAM, low address latch and node ID shift register
// ==========================================================
module tlh_ram_model
    import tlh_pkg::*;
#(
    parameter logic [7:0] NODE_ID = 8'hB2 // Switch setting, arbitrary
) (
    input wire logic mclk_i,
    input wire tlh_pkg::tlh_ram_t ram_i,
    input wire logic [7:0] bus_i,
    output logic [7:0] bus_o,
    input wire logic id_load_i,
    output logic id_serial_o
);
    logic [7:0] mem [256]; // Short frames only, bit 8 left open
    logic [7:0] addr_reg = 8'h00; // External low address latch
    logic [7:0] wdat = 8'h00; // Byte seen while the write pulse is high
    logic we_d = 1'b0; // Write pulse one edge ago
    logic [7:0] id_sr = 8'h00; // Parallel-in serial-out switch register
    logic [7:0] last = 8'h00; // Last byte the RAM drove

    // Start with a cleared buffer
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
    end

    // ======================================================
    // Latch, write and shift on the device clock
    // ======================================================
    always @(posedge mclk_i) begin
        if (ram_i.latch_pulse) addr_reg <= bus_i;
        if (ram_i.write_pulse) wdat <= bus_i;
        we_d <= ram_i.write_pulse;
        // Data is taken at the trailing edge of the pulse
        if (we_d && !ram_i.write_pulse) mem[addr_reg] <= wdat;
        if (ram_i.output_en) last <= mem[addr_reg];
        // Same clock as the device loads and shifts
        if (id_load_i) id_sr <= NODE_ID;
        else id_sr <= {id_sr[6:0], 1'b0};
    end

    // Released bus shows the inverse of the last byte
    assign bus_o = ram_i.output_en ? mem[addr_reg] : ~last;
    assign id_serial_o = id_sr[7]; // Most significant bit first
endmodule : tlh_ram_model

/* tb/tb.sv */
`timescale 1ns/10ps
// ==========================================================
// Testbench for the host and buffer port
// ==========================================================
module tb;
    import tlh_pkg::*;
    localparam logic [7:0] NODE_ID = 8'hB2; // Arbitrary switch setting
    logic mclk_i = 1'b0; // Device clock
    logic sys_rst_i = 1'b1; // Power-on reset
    logic strobe = 1'b1; // Address strobe, idle high
    tlh_req_t req = '0; // Cycle qualifiers
    logic lwv = 1'b0; // Late write data valid
    logic [7:0] pbus = 8'h00; // Processor byte
    logic [7:0] bdi, bdo, iface; // RAM side bytes and resolved bus
    logic bdoe, pgoe, ack, wt, irq, iface_latch_enable, addr_data_in_enable, upper_addr_in_enable, node_id_load, ids;
    logic [2:0] pg; // Upper buffer address
    tlh_ram_t ram; // RAM strobes
    logic [7:0] nid, stat;
    logic [1:0] tsel = 2'h0;
    logic [1:0] tso;
    logic inh_n = 1'b1, pa = 1'b0, pb = 1'b0, lpa, lpb;
    logic echo_n = 1'b1, rx_done = 1'b0, echo_req;
    logic [8:0] rx_len = 9'h000;
    logic [7:0] ev = 8'h00; // Status events
    logic [7:0] seen = 8'h00; // Strobes seen while waiting
    logic [1:0] pg_seen = 2'h0; // Page driven during an access
    logic [7:0] rd_seen = 8'h00; // Byte the RAM put on the bus
    int n_ld = 0, n_echo = 0, k = 0;
    int n_fail = 0;
    int comparisons = 0;

    initial forever #4 mclk_i = ~mclk_i; // 125 MHz
    // Device drive first, then the gated processor byte, else the RAM
    assign iface = bdoe ? bdo : (addr_data_in_enable ? pbus : bdi);

    // Collect what happens while a cycle is held
    always @(posedge mclk_i) begin
        if (wt === 1'b1) seen <= seen | {ram.latch_pulse, ram.write_pulse,
            ram.output_en, iface_latch_enable, addr_data_in_enable, upper_addr_in_enable, pgoe, ack};
        if (pgoe === 1'b1) pg_seen <= pg[2:1];
        if (ram.output_en === 1'b1) rd_seen <= iface;
        if (node_id_load === 1'b1) n_ld <= n_ld + 1;
        if (echo_req === 1'b1) n_echo <= n_echo + 1;
    end

    tlh_host_port i_tlh_host_port (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .addr_strobe_i(strobe), .req_i(req), .late_write_valid_i(lwv),
        .proc_addr_data_bus_i(pbus), .buffer_addr_data_bus_i(iface),
        .buffer_addr_data_bus_o(bdo), .buffer_addr_data_bus_oe_o(bdoe),
        .buffer_page_addr_hi_o(pg), .buffer_page_addr_hi_oe_o(pgoe),
        .request_ack_o(ack), .wait_o(wt), .irq_out_o(irq),
        .iface_latch_enable_o(iface_latch_enable), .addr_data_in_enable_o(addr_data_in_enable),
        .upper_addr_in_enable_o(upper_addr_in_enable), .ram_o(ram), .node_id_load_o(node_id_load),
        .node_id_serial_in_i(ids), .node_id_o(nid),
        .timeout_select_i(tsel), .tx_inhibit_n_i(inh_n),
        .tx_pulse_a_i(pa), .tx_pulse_b_i(pb), .line_pulse_a_o(lpa),
        .line_pulse_b_o(lpb), .echo_n_i(echo_n), .rx_len_i(rx_len),
        .rx_done_i(rx_done), .echo_req_o(echo_req), .event_i(ev),
        .status_o(stat), .timeout_sel_o(tso));

    tlh_ram_model #(.NODE_ID(NODE_ID)) i_tlh_ram_model (.mclk_i(mclk_i),
        .ram_i(ram), .bus_i(iface), .bus_o(bdi), .id_load_i(node_id_load),
        .id_serial_o(ids));

    // ======================================================
    // Shared tasks
    // ======================================================
    task automatic stop_test;
        $display("counts: %0d mismatches, %0d comparisons", n_fail,
            comparisons);
        if (n_fail == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask : chk

    // Step edges, then land just after the last one
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : tick

    // Bounded wait for the wait output to reach a level
    task automatic wait_wt(input logic v);
        k = 0;
        while (wt !== v) begin
            if (k == 20) begin
                n_fail++;
                stop_test;
            end
            tick(1);
            k++;
        end
    endtask : wait_wt

    // One processor cycle; reads also check the wait length
    task automatic cyc(input logic io, input logic rd, input logic [7:0] a,
        input logic [7:0] d, input int lag, input logic [7:0] exp_seen);
        seen = 8'h00;
        req = {io, ~io, rd};
        pbus = a;
        tick(1); // Qualifiers settle before the strobe falls
        strobe = 1'b0;
        wait_wt(1'b1);
        chk(k, 1);
        chk(ack, 1);
        if (!rd) begin
            if (lag > 0) tick(lag);
            chk(wt, 1);
            pbus = d;
            lwv = 1'b1;
        end
        wait_wt(1'b0);
        if (rd) chk(k, 4);
        chk(seen, exp_seen);
        strobe = 1'b1;
        req = '0;
        lwv = 1'b0;
        tick(1);
        chk(pgoe, 0);
        chk(ack, 0);
    endtask : cyc

    // Enable command with a page, then a buffer read on that page
    task automatic t_page(input logic [7:0] cmd, input logic [1:0] page);
        cyc(1'b1, 1'b0, 8'h00, cmd, 1, 8'h19);
        cyc(1'b0, 1'b1, 8'h5B, 8'h00, 0, 8'hAF);
        chk(pg_seen, page);
        chk(rd_seen, 8'h3C);
    endtask : t_page

    // One received message offered for echo
    task automatic t_echo(input logic e, input logic [8:0] len, input int x);
        echo_n = e;
        rx_len = len;
        n_echo = 0;
        rx_done = 1'b1;
        tick(1);
        rx_done = 1'b0;
        tick(4);
        chk(n_echo, x);
    endtask : t_echo

    // ======================================================
    // Main sequence
    // ======================================================
    initial begin
        tick(9);
        chk({wt, irq, lpa, lpb, pgoe}, 5'b01110);
        tick(1);
        sys_rst_i = 1'b0;
        tick(30);
        chk(n_ld, 1);
        chk(nid, NODE_ID);
        chk(stat[0], 1);
        // Buffer writes, slow then back to back with data ready
        cyc(1'b0, 1'b0, 8'h5A, 8'hC3, 3, 8'hDF);
        chk(i_tlh_ram_model.mem[8'h5A], 8'hC3);
        cyc(1'b0, 1'b0, 8'h5B, 8'h3C, 0, 8'hDF);
        chk(i_tlh_ram_model.mem[8'h5B], 8'h3C);
        cyc(1'b0, 1'b1, 8'h5A, 8'h00, 0, 8'hAF);
        chk(rd_seen, 8'hC3);
        t_page(8'h44, 2'h2);
        t_page(8'h32, 2'h1);
        // Inhibit, timeout select and a status event
        inh_n = 1'b0;
        tsel = 2'h2;
        ev = 8'h08;
        tick(1);
        ev = 8'h00;
        tick(2);
        chk({lpa, lpb}, 2'b11);
        chk(tso, 2'h2);
        chk(stat[3], 1);
        chk(irq, 1);
        inh_n = 1'b1;
        tick(2);
        chk({lpa, lpb}, 2'b00);
        // Mask in bit 3, clear it, then read the status back
        cyc(1'b1, 1'b0, 8'h00, 8'h09, 0, 8'h19);
        chk(irq, 1);
        cyc(1'b1, 1'b0, 8'h00, 8'h58, 0, 8'h19);
        chk(irq, 0);
        chk(stat, 8'h01);
        cyc(1'b1, 1'b1, 8'h01, 8'h00, 0, 8'h09);
        chk(bdo, 8'h01);
        t_echo(1'b0, 9'h0FD, 1);
        t_echo(1'b0, 9'h0FE, 0);
        t_echo(1'b1, 9'h00A, 0);
        stop_test;
    end
endmodule : tb
